// ==== rtl/gpc_pkg.sv ====
// package: register map, field layout and codes of the pin 5/6 configuration block
package gpc_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam int unsigned NPINS        = 2;
  localparam logic [7:0]  PIN5_CFG_OFS = 8'h30;
  localparam logic [7:0]  PIN6_CFG_OFS = 8'h34;
  localparam logic [7:0]  STATUS_OFS   = 8'h38;
  localparam logic [7:0]  OUTDATA_OFS  = 8'h3C;
  localparam logic [NPINS-1:0][7:0] PIN_CFG_OFS = {PIN6_CFG_OFS, PIN5_CFG_OFS};

  // ==========================================================================
  // codes
  typedef enum logic [2:0] {
    PULL_ANALOG   = 3'h0,
    PULL_RSVD1    = 3'h1,
    PULL_UP       = 3'h2,
    PULL_RSVD3    = 3'h3,
    PULL_DOWN     = 3'h4,
    PULL_PUSHPULL = 3'h5,
    PULL_RSVD6    = 3'h6,
    PULL_RSVD7    = 3'h7
  } gpc_pull_e;

  typedef enum logic [1:0] {
    FAULT_NONE = 2'h0,
    FAULT_LOW  = 2'h1,
    FAULT_HIGH = 2'h2,
    FAULT_RSVD = 2'h3
  } gpc_fault_e;

  // ==========================================================================
  // configuration byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic       spare;
    logic       strap_sel;
    logic       dir_in;
    gpc_pull_e  pull_drive_config;
    gpc_fault_e fault_mode;
  } gpc_cfg_s;

  // per-pin control and status, all registered
  typedef struct packed {
    logic pin_o;
    logic pin_oe_n;
    logic pull_up;
    logic pull_down;
    logic analog;
    logic strap_en;
    logic strap_lvl;
    logic level;
    logic fault;
  } gpc_pinst_s;

  localparam logic [7:0]  CFG_RESET   = 8'h30;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_IDLE = 2'h0;

endpackage

// ==== rtl/gpc_pin.sv ====
// module: one pin's drive, pull, strap and fault logic, all outputs registered
module gpc_pin (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // configuration
  input  wire gpc_pkg::gpc_cfg_s cfg,
  input  wire logic              out_val,
  // pad side
  input  wire logic              pin_i,
  output gpc_pkg::gpc_pinst_s    st
);

  // ==========================================================================
  // decode
  wire logic drive_en = ~cfg.dir_in &
                        (cfg.pull_drive_config == gpc_pkg::PULL_PUSHPULL);
  wire logic pu_en    = (cfg.pull_drive_config == gpc_pkg::PULL_UP);
  // pulldown follows the code alone; input-only use is software's duty
  wire logic pd_en    = (cfg.pull_drive_config == gpc_pkg::PULL_DOWN);
  wire logic ana_en   = (cfg.pull_drive_config == gpc_pkg::PULL_ANALOG);
  // reserved fault code signals nothing, so a stray write cannot raise a fault
  wire logic flt      = ((cfg.fault_mode == gpc_pkg::FAULT_LOW)  & ~pin_i) |
                        ((cfg.fault_mode == gpc_pkg::FAULT_HIGH) &  pin_i);

  gpc_pkg::gpc_pinst_s st_d;
  assign st_d.pin_o     = drive_en & out_val;
  assign st_d.pin_oe_n  = ~drive_en;
  assign st_d.pull_up   = pu_en;
  assign st_d.pull_down = pd_en;
  assign st_d.analog    = ana_en;
  assign st_d.strap_en  = cfg.strap_sel;
  assign st_d.strap_lvl = cfg.strap_sel & pin_i;
  assign st_d.level     = pin_i;
  assign st_d.fault     = flt;

  // ==========================================================================
  // registers; reset state matches the reset configuration (input, pulldown)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{pin_o: 1'b0, pin_oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b1,
              analog: 1'b0, strap_en: 1'b0, strap_lvl: 1'b0, level: 1'b0,
              fault: 1'b0};
    end else begin
      st <= st_d;
    end
  end

endmodule

// ==== rtl/gpc_top.sv ====
// module: AHB-Lite register slave and two configurable general-purpose pins
//
// Notes on behaviour
// - direction bit 0 makes the pin an output, 1 an input.
// - pull code 000 is analog input, no pull resistor, for conversion only.
// - code 010 enables weak pullup, 100 weak pulldown (pulldown for inputs).
// - code 101 selects push-pull drive, meant for output mode only.
// - fault code 00 never faults, 01 faults when low, 10 when high.
// - pin 6 register at 0x34 resets to input, pulldown, strap and fault off.
module gpc_top #(
  parameter int unsigned NPINS = gpc_pkg::NPINS
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              SYS_RST,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  output logic [31:0]            HRDATA,
  // pins, index 0 is pin 5, index 1 is pin 6
  input  wire logic [NPINS-1:0]  GPIO_IN,
  output logic [NPINS-1:0]       GPIO_OUT,
  output logic [NPINS-1:0]       GPIO_OE_N,
  output logic [NPINS-1:0]       PULLUP_EN,
  output logic [NPINS-1:0]       PULLDOWN_EN,
  output logic [NPINS-1:0]       ANALOG_EN,
  // address strap and fault summary
  output logic [NPINS-1:0]       ADDR_STRAP_EN,
  output logic [NPINS-1:0]       ADDR_STRAP_LVL,
  output logic [NPINS-1:0]       PIN_FAULT
);

  // ==========================================================================
  // address phase
  // HSIZE is not checked: only whole-word transfers are expected
  wire logic       take    = HSEL & HTRANS[1] & HREADY;
  wire logic [7:0] a_ofs   = HADDR[7:0];
  wire logic       a_upper = (HADDR[31:8] == 24'h00_0000);

  logic       wr_q;
  logic [7:0] wofs_q;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_q   <= 1'b0;
      wofs_q <= 8'h00;
    end else begin
      wr_q   <= take & HWRITE & a_upper;
      wofs_q <= a_ofs;
    end
  end

  // ==========================================================================
  // configuration and output data registers
  gpc_pkg::gpc_cfg_s [NPINS-1:0] cfg_q;
  gpc_pkg::gpc_cfg_s [NPINS-1:0] cfg_d;
  gpc_pkg::gpc_pinst_s [NPINS-1:0] st;
  logic [NPINS-1:0] outd_q;
  logic [NPINS-1:0] level_w;
  logic [NPINS-1:0] fault_w;

  // read data is built from next values so a read right after a write sees it
  wire logic             wr_out = wr_q & (wofs_q == gpc_pkg::OUTDATA_OFS);
  wire logic [NPINS-1:0] outd_d = wr_out ? HWDATA[NPINS-1:0] : outd_q;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      // reserved codes are stored as written; the decode gives them no effect
      wire logic wr_cfg = wr_q & (wofs_q == gpc_pkg::PIN_CFG_OFS[gi]);
      assign cfg_d[gi] = wr_cfg ? gpc_pkg::gpc_cfg_s'(HWDATA[7:0]) : cfg_q[gi];

      always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          cfg_q[gi] <= gpc_pkg::gpc_cfg_s'(gpc_pkg::CFG_RESET);
        end else begin
          cfg_q[gi] <= cfg_d[gi];
        end
      end

      gpc_pin u_pin (
        .clk     (REF_CLK),
        .rst     (SYS_RST),
        .cfg     (cfg_q[gi]),
        .out_val (outd_q[gi]),
        .pin_i   (GPIO_IN[gi]),
        .st      (st[gi])
      );

      assign GPIO_OUT[gi]       = st[gi].pin_o;
      assign GPIO_OE_N[gi]      = st[gi].pin_oe_n;
      assign PULLUP_EN[gi]      = st[gi].pull_up;
      assign PULLDOWN_EN[gi]    = st[gi].pull_down;
      assign ANALOG_EN[gi]      = st[gi].analog;
      assign ADDR_STRAP_EN[gi]  = st[gi].strap_en;
      assign ADDR_STRAP_LVL[gi] = st[gi].strap_lvl;
      assign PIN_FAULT[gi]      = st[gi].fault;
      assign level_w[gi]        = st[gi].level;
      assign fault_w[gi]        = st[gi].fault;
    end
  endgenerate

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      outd_q <= '0;
    end else begin
      outd_q <= outd_d;
    end
  end

  // ==========================================================================
  // read mux; unmapped addresses read zero
  wire logic [31:0] rd_pin5 = {24'h00_0000, cfg_d[0]};
  wire logic [31:0] rd_pin6 = {24'h00_0000, cfg_d[1]};
  wire logic [31:0] rd_stat = {28'h000_0000, fault_w, level_w};
  wire logic [31:0] rd_outd = {30'h0000_0000, outd_d};
  wire logic        rd_take = take & ~HWRITE & a_upper;
  wire logic [31:0] rd_word =
      ~rd_take                         ? gpc_pkg::RDATA_ZERO :
      (a_ofs == gpc_pkg::PIN5_CFG_OFS) ? rd_pin5 :
      (a_ofs == gpc_pkg::PIN6_CFG_OFS) ? rd_pin6 :
      (a_ofs == gpc_pkg::STATUS_OFS)   ? rd_stat :
      (a_ofs == gpc_pkg::OUTDATA_OFS)  ? rd_outd : gpc_pkg::RDATA_ZERO;

  // zero-wait slave: always ready, always OKAY
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= gpc_pkg::RDATA_ZERO;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= rd_word;
    end
  end

endmodule

// ==== bench/gpc_sva.sv ====
// checker: port-level relations of the pin configuration block
module gpc_sva #(
  parameter int unsigned NPINS = 2
) (
  // clock and reset
  input wire logic             REF_CLK,
  input wire logic             SYS_RST,
  // bus
  input wire logic             HSEL,
  input wire logic [1:0]       HTRANS,
  input wire logic             HWRITE,
  input wire logic             HREADY,
  input wire logic             HREADYOUT,
  input wire logic             HRESP,
  input wire logic [31:0]      HRDATA,
  // pins
  input wire logic [NPINS-1:0] GPIO_IN,
  input wire logic [NPINS-1:0] GPIO_OUT,
  input wire logic [NPINS-1:0] GPIO_OE_N,
  input wire logic [NPINS-1:0] PULLUP_EN,
  input wire logic [NPINS-1:0] PULLDOWN_EN,
  input wire logic [NPINS-1:0] ANALOG_EN,
  input wire logic [NPINS-1:0] ADDR_STRAP_EN,
  input wire logic [NPINS-1:0] ADDR_STRAP_LVL,
  input wire logic [NPINS-1:0] PIN_FAULT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  wire go = HSEL && HTRANS[1] && HREADY;
  // ==========================================
  // sequences and properties
  sequence s_rd; go && !HWRITE; endsequence
  // no bus write two edges back, pin level unchanged
  sequence s_quiet; !(go && HWRITE) ##2 $stable(GPIO_IN[1]); endsequence
  property p_bus_ok; HREADYOUT && !HRESP; endproperty
  property p_rd_idle; !go || HWRITE |=> HRDATA == 32'h0000_0000; endproperty
  property p_rd_upper; s_rd |=> HRDATA[31:8] == 24'h00_0000; endproperty
  property p_pp_only; !GPIO_OE_N[0] |-> !(PULLUP_EN[0] || PULLDOWN_EN[0] || ANALOG_EN[0]);
  endproperty
  property p_analog; ANALOG_EN[1] |-> GPIO_OE_N[1] && !PULLUP_EN[1] && !PULLDOWN_EN[1];
  endproperty
  property p_pull_one; PULLUP_EN[0] |-> !PULLDOWN_EN[0] && !ANALOG_EN[0]; endproperty
  property p_undriven; GPIO_OE_N[1] |-> !GPIO_OUT[1]; endproperty
  property p_strap; ADDR_STRAP_LVL[0] == (ADDR_STRAP_EN[0] && $past(GPIO_IN[0])); endproperty
  property p_fault_hold; s_quiet ##0 PIN_FAULT[1] |=> PIN_FAULT[1]; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready/okay");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  a_pp_only: assert property (p_pp_only) else $error("drive with pull on");
  a_analog: assert property (p_analog) else $error("analog pin not bare");
  a_pull_one: assert property (p_pull_one) else $error("pull clash");
  a_undriven: assert property (p_undriven) else $error("value on undriven pin");
  a_strap: assert property (p_strap) else $error("strap level wrong");
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
endmodule

// ==== bench/gpc_pin_env.sv ====
// partner: external drivers on the two pins, with pull and float behaviour
module gpc_pin_env (
  input  wire logic       clk,
  input  wire logic [1:0] ext_en,
  input  wire logic [1:0] ext_lvl,
  input  wire logic [1:0] oe_n,
  input  wire logic [1:0] dout,
  input  wire logic [1:0] pu,
  input  wire logic [1:0] pd,
  output logic [1:0]      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] flt_q = 2'h0;
  // a released pin wanders, so a stale level never passes
  always @(posedge clk) flt_q <= ~flt_q;
  always_comb for (int i = 0; i < 2; i++)
    pin[i] = !oe_n[i] ? dout[i] : ext_en[i] ? ext_lvl[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : flt_q[i];
endmodule

// ==== bench/gpc_top_test.sv ====
// testbench: bus access, pin behaviour and reset state of the pin block
module gpc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'h0, ext_en = 2'h0, ext_lvl = 2'h0, in_smp, od;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd, rnd = 32'hBCA0;
  logic        HREADYOUT, HRESP;
  logic [1:0]  GPIO_IN, GPIO_OUT, GPIO_OE_N, PULLUP_EN, PULLDOWN_EN, ANALOG_EN;
  logic [1:0]  ADDR_STRAP_EN, ADDR_STRAP_LVL, PIN_FAULT;
  logic [7:0]  cfg [2];
  int          error_cnt = 0, samples_checked = 0;
  wire         HREADY = HREADYOUT;
  gpc_top u_dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .GPIO_IN(GPIO_IN),
    .GPIO_OUT(GPIO_OUT), .GPIO_OE_N(GPIO_OE_N), .PULLUP_EN(PULLUP_EN),
    .PULLDOWN_EN(PULLDOWN_EN), .ANALOG_EN(ANALOG_EN), .ADDR_STRAP_EN(ADDR_STRAP_EN),
    .ADDR_STRAP_LVL(ADDR_STRAP_LVL), .PIN_FAULT(PIN_FAULT));
  gpc_pin_env u_env (.clk(REF_CLK), .ext_en(ext_en), .ext_lvl(ext_lvl), .oe_n(GPIO_OE_N),
    .dout(GPIO_OUT), .pu(PULLUP_EN), .pd(PULLDOWN_EN), .pin(GPIO_IN));
  initial forever #2 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) in_smp <= GPIO_IN;
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // legal pull and fault codes only: software keeps the reserved ones out
  function automatic logic [5:0] legal_cfg(logic [5:0] m);
    logic [2:0] pull;
    logic [2:0] flt;
    pull = (m[2:1] == 2'h0) ? 3'h0 : (m[2:1] == 2'h1) ? 3'h2 : (m[2:1] == 2'h2) ? 3'h4 : 3'h5;
    flt = m[5:3] % 3'h3;
    return {m[0], pull, flt[1:0]};
  endfunction
  function automatic logic [7:0] exp_pin(logic [7:0] c, logic o, logic lv);
    logic drv;
    drv = !c[5] && c[4:2] == 3'h5;
    return {drv & o, !drv, c[4:2] == 3'h2, c[4:2] == 3'h4, c[4:2] == 3'h0, c[6], c[6] & lv,
      (c[1:0] == 2'h1 && !lv) || (c[1:0] == 2'h2 && lv)};
  endfunction
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_pins;
    #1;
    for (int i = 0; i < 2; i++)
      cmp("pin", {24'h0, exp_pin(cfg[i], od[i], in_smp[i])}, {24'h0, GPIO_OUT[i],
        GPIO_OE_N[i], PULLUP_EN[i], PULLDOWN_EN[i], ANALOG_EN[i], ADDR_STRAP_EN[i],
        ADDR_STRAP_LVL[i], PIN_FAULT[i]});
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic chk_reset;
    cfg = '{8'h30, 8'h30};
    od = 2'h0;
    ahb(1'b0, 32'h34, 32'h0, rd);
    cmp("cfg6", 32'h30, rd);
    ahb(1'b0, 32'h30, 32'h0, rd);
    cmp("cfg5", 32'h30, rd);
    ahb(1'b0, 32'h3C, 32'h0, rd);
    cmp("outd", 32'h0, rd);
    chk_pins;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    chk_reset;
    $display("test reset done");
    // every legal pull, direction and fault code on both pins
    for (int k = 0; k < 128; k++) begin
      rnd = lfsr(rnd);
      od = rnd[13:12];
      cfg[k % 2] = {rnd[7:6], legal_cfg(k[6:1])};
      ahb(1'b1, 32'h3C, {30'h0, od}, rd);
      ext_en <= rnd[9:8];
      ext_lvl <= rnd[11:10];
      ahb(1'b1, {24'h0, gpc_pkg::PIN_CFG_OFS[k % 2]}, {24'h0, cfg[k % 2]}, rd);
      ahb(1'b0, {24'h0, gpc_pkg::PIN_CFG_OFS[k % 2]}, 32'h0, rd);
      cmp("cfg", {24'h0, cfg[k % 2]}, rd);
      ahb(1'b0, 32'h3C, 32'h0, rd);
      cmp("outd", {30'h0, od}, rd);
      repeat (3) @(posedge REF_CLK);
      chk_pins;
    end
    $display("test codes done");
    // reset in mid-run must bring back the reset configuration
    @(posedge REF_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    chk_reset;
    $display("test mid-run reset done");
    ahb(1'b1, 32'h104, 32'hFF, rd);
    ahb(1'b0, 32'h104, 32'h0, rd);
    cmp("unmapped", 32'h0, rd);
    $display("test unmapped done");
    report_and_stop;
  end
endmodule
bind gpc_top gpc_sva #(.NPINS(NPINS)) u_sva (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .HRDATA(HRDATA), .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT),
  .GPIO_OE_N(GPIO_OE_N), .PULLUP_EN(PULLUP_EN), .PULLDOWN_EN(PULLDOWN_EN),
  .ANALOG_EN(ANALOG_EN), .ADDR_STRAP_EN(ADDR_STRAP_EN), .ADDR_STRAP_LVL(ADDR_STRAP_LVL),
  .PIN_FAULT(PIN_FAULT));
